// ### core/pmdp_pkg.sv
package pmdp_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 40;

  // MII clock periods per speed
  localparam int MII10_PERIOD_NS = 400;
  localparam int MII100_PERIOD_NS = 40;
  localparam int HALF10_RAW = (MII10_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int HALF100_RAW = (MII100_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int HALF10_CYCLES = (HALF10_RAW < 1) ? 1 : HALF10_RAW;
  localparam int HALF100_CYCLES = (HALF100_RAW < 1) ? 1 : HALF100_RAW;
  localparam int DIV_W = 4;

  // Reset extension
  localparam int RST_EXT_NS = 258000;
  localparam int RST_EXT_CYCLES = (RST_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 16;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LED_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Control register fields
  localparam int CTRL_SOFT_RST_BIT = 15;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_PWRDN_BIT = 11;
  localparam int CTRL_ISO_BIT = 10;
  localparam int CTRL_DUPLEX_BIT = 8;

  // Control reset values
  localparam logic RST_SPEED = 1'b1;
  localparam logic RST_DUPLEX = 1'b0;
  localparam logic RST_PWRDN = 1'b0;
  localparam logic RST_ISO = 1'b0;

  // LED source selects, two bits per pin, pin one in the low field
  localparam int LED_SEL_W = 2;
  localparam int LED_CFG_W = 6;
  localparam logic [1:0] LED_CARRIER = 2'h0;
  localparam logic [1:0] LED_COLL = 2'h1;
  localparam logic [1:0] LED_RX = 2'h2;
  localparam logic [1:0] LED_TX = 2'h3;
  localparam logic [5:0] LED_CFG_DEF = 6'h38;
  localparam logic [5:0] LED_CFG_ALT = 6'h18;

  // Status register fields
  localparam int STAT_STRAP_LSB = 0;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_CRS_BIT = 4;
  localparam int STAT_COL_BIT = 5;

  // AHB-Lite
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    RST_HOLD = 2'b00,
    RST_COUNT = 2'b01,
    RST_RUN = 2'b11
  } pmdp_rst_state_t;

endpackage

// ### core/pmdp_rst_ext.sv
`timescale 1ns/10ps
`default_nettype none
module pmdp_rst_ext #(
  parameter int EXT_CYCLES = pmdp_pkg::RST_EXT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Soft reset request, one-cycle pulse
  input wire logic soft_req,
  // Internal reset state
  output logic busy,
  output logic done
);

  pmdp_pkg::pmdp_rst_state_t state_q, state_d;
  logic [pmdp_pkg::RST_CNT_W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  localparam logic [pmdp_pkg::RST_CNT_W-1:0] LAST =
    pmdp_pkg::RST_CNT_W'(EXT_CYCLES - 1);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    case (state_q)
      pmdp_pkg::RST_HOLD: begin
        state_d = pmdp_pkg::RST_COUNT;
        cnt_d = '0;
      end
      pmdp_pkg::RST_COUNT: begin
        // Count restarts on soft_req mid-count; the top ignores writes while busy, so never raises it then
        if (soft_req) begin
          cnt_d = '0;
        end else if (cnt_q == LAST) begin
          state_d = pmdp_pkg::RST_RUN;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      pmdp_pkg::RST_RUN: begin
        if (soft_req) begin
          state_d = pmdp_pkg::RST_HOLD;
        end
      end
      default: begin
        state_d = pmdp_pkg::RST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= pmdp_pkg::RST_HOLD;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (state_q != pmdp_pkg::RST_RUN);
  assign done = done_q;

endmodule
`default_nettype wire

// ### core/pmdp_top.sv
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pmdp_top #(
  parameter int RST_EXT = pmdp_pkg::RST_EXT_CYCLES,
  parameter int HALF10 = pmdp_pkg::HALF10_CYCLES,
  parameter int HALF100 = pmdp_pkg::HALF100_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // MII transmit
  input wire logic [3:0] txd,
  input wire logic tx_en,
  output logic tx_clk,
  // MII receive
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic rx_clk,
  output logic col,
  output logic crs,
  output logic mii_out_en,
  // Line side
  input wire logic [3:0] line_rx_nibble,
  input wire logic line_rx_valid,
  input wire logic line_rx_error,
  input wire logic line_carrier,
  input wire logic line_collision,
  output logic [3:0] line_tx_nibble,
  output logic line_tx_en,
  // LED and strap pins
  input wire logic led_strap_pin_one_level,
  output logic led_strap_pin_one_drive,
  output logic led_strap_pin_one_oe,
  input wire logic led_strap_pin_two_level,
  output logic led_strap_pin_two_drive,
  output logic led_strap_pin_two_oe,
  input wire logic led_strap_pin_three_level,
  output logic led_strap_pin_three_drive,
  output logic led_strap_pin_three_oe,
  // Boundary scan
  input wire logic tck,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  // Mode status
  output logic hardware_reset_state,
  output logic soft_power_down_mode
);

  function automatic logic led_pick(input logic [1:0] sel, input logic c_crs,
                                    input logic c_col, input logic c_rx,
                                    input logic c_tx);
    logic v;
    v = 1'b0;
    case (sel)
      pmdp_pkg::LED_CARRIER: v = c_crs;
      pmdp_pkg::LED_COLL: v = c_col;
      pmdp_pkg::LED_RX: v = c_rx;
      pmdp_pkg::LED_TX: v = c_tx;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SYNC_W = 11;
  logic [SYNC_W-1:0] s1_q, s2_q;
  logic [3:0] txd_s;
  logic tx_en_s, tck_s, tdi_s, trst_s;
  logic [2:0] led_s;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {txd, tx_en, led_strap_pin_three_level, led_strap_pin_two_level,
               led_strap_pin_one_level, tck, tdi, trst_n};
      s2_q <= s1_q;
    end
  end
  assign {txd_s, tx_en_s, led_s, tck_s, tdi_s, trst_s} = s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset extension and mode
  logic soft_req, busy, rst_done, run;
  logic speed_q, speed_d, fd_q, fd_d, pd_q, pd_d, iso_q, iso_d;
  logic [pmdp_pkg::LED_CFG_W-1:0] led_cfg_q, led_cfg_d;
  logic [2:0] strap_q, strap_d;

  pmdp_rst_ext #(
    .EXT_CYCLES(RST_EXT)
  ) u_rst_ext (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .soft_req(soft_req),
    .busy(busy),
    .done(rst_done)
  );

  assign run = !busy && !pd_q;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  logic dp_wr_q, dp_wr_d;
  logic [pmdp_pkg::ADDR_W-1:0] dp_addr_q, dp_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic addr_ok;
  logic col_q, col_d, crs_q, crs_d;

  function automatic logic [31:0] read_word(
    input logic [7:0] a, input logic sp, input logic f, input logic p,
    input logic i, input logic [5:0] lc, input logic [2:0] st, input logic b,
    input logic c_crs, input logic c_col);
    logic [31:0] w;
    w = '0;
    case (a)
      pmdp_pkg::ADDR_CTRL: begin
        w[pmdp_pkg::CTRL_SOFT_RST_BIT] = b;
        w[pmdp_pkg::CTRL_SPEED_BIT] = sp;
        w[pmdp_pkg::CTRL_PWRDN_BIT] = p;
        w[pmdp_pkg::CTRL_ISO_BIT] = i;
        w[pmdp_pkg::CTRL_DUPLEX_BIT] = f;
      end
      pmdp_pkg::ADDR_LED_CFG: w[pmdp_pkg::LED_CFG_W-1:0] = lc;
      pmdp_pkg::ADDR_STATUS: begin
        w[pmdp_pkg::STAT_STRAP_LSB +: 3] = st;
        w[pmdp_pkg::STAT_BUSY_BIT] = b;
        w[pmdp_pkg::STAT_CRS_BIT] = c_crs;
        w[pmdp_pkg::STAT_COL_BIT] = c_col;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  assign addr_ok = hsel && htrans[pmdp_pkg::HTRANS_ACTIVE_BIT] && hready;

  always_comb begin
    dp_wr_d = addr_ok && hwrite && (hsize == pmdp_pkg::HSIZE_WORD);
    dp_addr_d = haddr[pmdp_pkg::ADDR_W-1:0];
    soft_req = 1'b0;
    speed_d = speed_q;
    fd_d = fd_q;
    pd_d = pd_q;
    iso_d = iso_q;
    led_cfg_d = led_cfg_q;
    // Straps track the pins until the extension ends, then freeze
    strap_d = busy ? led_s : strap_q;
    if (rst_done) begin
      speed_d = strap_q[0];
      fd_d = strap_q[1];
      pd_d = pmdp_pkg::RST_PWRDN;
      iso_d = pmdp_pkg::RST_ISO;
      led_cfg_d = strap_q[2] ? pmdp_pkg::LED_CFG_ALT : pmdp_pkg::LED_CFG_DEF;
    end else if (dp_wr_q && !busy) begin
      if (dp_addr_q == pmdp_pkg::ADDR_CTRL) begin
        soft_req = hwdata[pmdp_pkg::CTRL_SOFT_RST_BIT];
        speed_d = hwdata[pmdp_pkg::CTRL_SPEED_BIT];
        pd_d = hwdata[pmdp_pkg::CTRL_PWRDN_BIT];
        iso_d = hwdata[pmdp_pkg::CTRL_ISO_BIT];
        fd_d = hwdata[pmdp_pkg::CTRL_DUPLEX_BIT];
      end else if (dp_addr_q == pmdp_pkg::ADDR_LED_CFG) begin
        led_cfg_d = hwdata[pmdp_pkg::LED_CFG_W-1:0];
      end
    end
    // Built from next values so a read right behind a write sees it
    rdata_d = rdata_q;
    if (addr_ok && !hwrite) begin
      rdata_d = read_word(dp_addr_d, speed_d, fd_d, pd_d, iso_d, led_cfg_d,
                          strap_q, busy, crs_q, col_q);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= '0;
      rdata_q <= '0;
      speed_q <= pmdp_pkg::RST_SPEED;
      fd_q <= pmdp_pkg::RST_DUPLEX;
      pd_q <= pmdp_pkg::RST_PWRDN;
      iso_q <= pmdp_pkg::RST_ISO;
      led_cfg_q <= pmdp_pkg::LED_CFG_DEF;
      strap_q <= '0;
    end else begin
      dp_wr_q <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      rdata_q <= rdata_d;
      speed_q <= speed_d;
      fd_q <= fd_d;
      pd_q <= pd_d;
      iso_q <= iso_d;
      led_cfg_q <= led_cfg_d;
      strap_q <= strap_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = pmdp_pkg::HRESP_OKAY;
  assign hrdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // MII clock divider; 100M cannot exceed half the system clock
  logic [pmdp_pkg::DIV_W-1:0] div_q, div_d, half_m1;
  logic mclk_q, mclk_d, mii_rise;

  assign half_m1 = speed_q ? pmdp_pkg::DIV_W'(HALF100 - 1)
                           : pmdp_pkg::DIV_W'(HALF10 - 1);

  always_comb begin
    div_d = div_q + 1'b1;
    mclk_d = mclk_q;
    if (busy) begin
      div_d = '0;
      mclk_d = 1'b1;
    end else if (div_q >= half_m1) begin
      div_d = '0;
      mclk_d = !mclk_q;
    end
  end
  assign mii_rise = !busy && (div_q >= half_m1) && !mclk_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      mclk_q <= 1'b1;
    end else begin
      div_q <= div_d;
      mclk_q <= mclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data paths, carrier and collision
  logic [3:0] rxd_q, rxd_d, ltx_q, ltx_d;
  logic dv_q, dv_d, er_q, er_d, ltxen_q, ltxen_d, oe_q, oe_d;

  always_comb begin
    rxd_d = rxd_q;
    dv_d = dv_q;
    er_d = er_q;
    ltx_d = ltx_q;
    ltxen_d = ltxen_q;
    if (!run) begin
      rxd_d = '0;
      dv_d = 1'b0;
      er_d = 1'b0;
      ltx_d = '0;
      ltxen_d = 1'b0;
    end else if (mii_rise) begin
      rxd_d = line_rx_valid ? line_rx_nibble : '0;
      dv_d = line_rx_valid;
      er_d = line_rx_error;
      ltx_d = txd_s;
      ltxen_d = tx_en_s;
    end
    // Own transmission counts as carrier only in half duplex
    crs_d = crs_q;
    if (!run) begin
      crs_d = 1'b0;
    end else if (line_carrier || (!fd_q && ltxen_q)) begin
      crs_d = 1'b1;
    end else if (mii_rise) begin
      crs_d = 1'b0;
    end
    col_d = run && !fd_q && line_collision;
    oe_d = !iso_q;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxd_q <= '0;
      dv_q <= 1'b0;
      er_q <= 1'b0;
      ltx_q <= '0;
      ltxen_q <= 1'b0;
      crs_q <= 1'b0;
      col_q <= 1'b0;
      oe_q <= 1'b1;
    end else begin
      rxd_q <= rxd_d;
      dv_q <= dv_d;
      er_q <= er_d;
      ltx_q <= ltx_d;
      ltxen_q <= ltxen_d;
      crs_q <= crs_d;
      col_q <= col_d;
      oe_q <= oe_d;
    end
  end

  assign tx_clk = mclk_q;
  assign rx_clk = mclk_q;
  assign rxd = rxd_q;
  assign rx_dv = dv_q;
  assign rx_er = er_q;
  assign crs = crs_q;
  assign col = col_q;
  assign mii_out_en = oe_q;
  assign line_tx_nibble = ltx_q;
  assign line_tx_en = ltxen_q;
  assign hardware_reset_state = busy;
  assign soft_power_down_mode = pd_q;

  ////////////////////////////////////////////////////////////////////////////
  // LED drivers; pins float while straps are being read
  logic [2:0] led_q, led_d;

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      led_d[k] = busy ? 1'b0 :
        led_pick(led_cfg_q[k*pmdp_pkg::LED_SEL_W +: pmdp_pkg::LED_SEL_W],
                 crs_q, col_q, dv_q, ltxen_q);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      led_q <= '0;
    end else begin
      led_q <= led_d;
    end
  end

  assign {led_strap_pin_three_drive, led_strap_pin_two_drive,
          led_strap_pin_one_drive} = led_q;
  assign led_strap_pin_one_oe = !busy;
  assign led_strap_pin_two_oe = !busy;
  assign led_strap_pin_three_oe = !busy;

  ////////////////////////////////////////////////////////////////////////////
  // Boundary scan bypass stage
  logic tck_prev_q, byp_q, byp_d, tdo_q, tdo_d, tck_rise, tck_fall;

  assign tck_rise = tck_s && !tck_prev_q;
  assign tck_fall = !tck_s && tck_prev_q;

  always_comb begin
    byp_d = byp_q;
    tdo_d = tdo_q;
    if (!trst_s) begin
      byp_d = 1'b0;
      tdo_d = 1'b0;
    end else begin
      if (tck_rise) begin
        byp_d = tdi_s;
      end
      if (tck_fall) begin
        tdo_d = byp_q;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tck_prev_q <= 1'b0;
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
      byp_q <= byp_d;
      tdo_q <= tdo_d;
    end
  end
  assign tdo = tdo_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  col_fdx_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fd_q && $past(fd_q) |-> !col_q) else $error("collision in full duplex");

  col_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (line_collision && run && !fd_q)[*3] |-> col_q)
    else $error("collision not held");

  crs_fall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(crs_q) && $past(run) |-> $past(mii_rise))
    else $error("carrier sense fell off clock edge");

  rxdv_edge_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(dv_q) && run && $past(run) |-> $past(mii_rise))
    else $error("receive valid moved off clock edge");

  clk10_half_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(mclk_q) && !speed_q && !busy |->
      mclk_q[*5] ##1 (!mclk_q || busy || speed_q))
    else $error("10M clock half period wrong");

  hwrst_pins_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    busy && $past(busy) |-> tx_clk && rx_clk && rxd == '0 && !rx_dv && !rx_er
      && !col && !crs) else $error("pins wrong in hardware reset");

  pwrdn_pins_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pd_q && $past(pd_q) && !busy |-> rxd == '0 && !rx_dv && !rx_er && !col
      && !crs) else $error("pins wrong in power-down");

  iso_float_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    iso_q && $past(iso_q) |-> !mii_out_en) else $error("drive in isolate");

  soft_rst_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    dp_wr_q && !busy && !rst_done && dp_addr_q == pmdp_pkg::ADDR_CTRL &&
      hwdata[pmdp_pkg::CTRL_SOFT_RST_BIT] |-> ##[1:3] busy)
    else $error("soft reset not started");

  tdi_rise_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(byp_q) && trst_s && $past(trst_s) |-> $past(tck_rise))
    else $error("test data sampled off rising edge");

  tdo_fall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(tdo_q) && trst_s && $past(trst_s) |-> $past(tck_fall))
    else $error("test data out moved off falling edge");

endmodule
`default_nettype wire

// ### testbench/pmdp_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmdp_mac_model (
  // MII clocks as seen on the wire
  input wire logic mii_txc,
  input wire logic mii_rxc,
  // Receive path from the device
  input wire logic [3:0] rxd_w,
  input wire logic rx_dv_w,
  input wire logic rx_er_w,
  // Frame request from the bench
  input wire logic go,
  // Transmit path to the device
  output logic [3:0] txd,
  output logic tx_en,
  // Receive record
  output logic [15:0] rx_acc,
  output logic [3:0] rx_cnt,
  output logic er_seen
);
  // Only the data port is modelled; no management clock leaves this side
  logic [2:0] idx;
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    idx = 3'h0;
    rx_acc = 16'h0000;
    rx_cnt = 4'h0;
    er_seen = 1'b0;
  end
  // Four one-hot nibbles, then the idle data line shows the inverse of its last value
  always @(posedge mii_txc) begin
    if (go && idx < 3'h4) begin
      tx_en <= 1'b1;
      txd <= 4'h1 << idx;
      idx <= idx + 3'h1;
    end else begin
      tx_en <= 1'b0;
      txd <= ~txd;
      if (!go) idx <= 3'h0;
    end
  end
  // Sampled mid-period, since the device moves its data together with the clock rise
  always @(negedge mii_rxc) begin
    if (rx_dv_w) begin
      rx_acc <= {rx_acc[11:0], rxd_w};
      rx_cnt <= rx_cnt + 4'h1;
    end
    if (rx_er_w) er_seen <= 1'b1;
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int EXT = 8;
  localparam int H10 = pmdp_pkg::HALF10_CYCLES;
  localparam int H100 = pmdp_pkg::HALF100_CYCLES;
  localparam logic [31:0] SPD = 32'h00000001 << pmdp_pkg::CTRL_SPEED_BIT;
  localparam logic [31:0] FDX = 32'h00000001 << pmdp_pkg::CTRL_DUPLEX_BIT;
  localparam logic [31:0] PWD = 32'h00000001 << pmdp_pkg::CTRL_PWRDN_BIT;
  localparam logic [31:0] ISO = 32'h00000001 << pmdp_pkg::CTRL_ISO_BIT;
  localparam logic [31:0] SRST = 32'h00000001 << pmdp_pkg::CTRL_SOFT_RST_BIT;
  logic clk_sys, reset_n, hwrite, hreadyout, hresp, tx_en, go, er_seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] txd, rxd, rx_cnt, lnb, ltx;
  logic tx_clk, rx_clk, rx_dv, rx_er, col, crs, oen, lv, le, lc, lcol, ltx_en;
  logic d1, d2, d3, o1, o2, o3, s1, s2, s3, tck, tdi, trst_n, tdo, hrst, spd_mode, drv;
  logic [15:0] rx_acc, tx_acc;
  int n_mismatch, cmp_count, tx_n, cyc;
  // Isolated outputs float onto their weak pull-downs
  wire logic tx_clk_w = oen ? tx_clk : 1'b0;
  wire logic rx_clk_w = oen ? rx_clk : 1'b0;
  wire logic [3:0] rxd_w = oen ? rxd : 4'h0;
  wire logic rx_dv_w = oen ? rx_dv : 1'b0;
  wire logic rx_er_w = oen ? rx_er : 1'b0;
  wire logic p1 = o1 ? d1 : s1;
  wire logic p2 = o2 ? d2 : s2;
  wire logic p3 = o3 ? d3 : s3;
  pmdp_top #(.RST_EXT(EXT), .HALF10(H10), .HALF100(H100)) i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txd(txd), .tx_en(tx_en),
    .tx_clk(tx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .rx_clk(rx_clk), .col(col),
    .crs(crs), .mii_out_en(oen), .line_rx_nibble(lnb), .line_rx_valid(lv),
    .line_rx_error(le), .line_carrier(lc), .line_collision(lcol), .line_tx_nibble(ltx),
    .line_tx_en(ltx_en), .led_strap_pin_one_level(p1), .led_strap_pin_one_drive(d1),
    .led_strap_pin_one_oe(o1), .led_strap_pin_two_level(p2), .led_strap_pin_two_drive(d2),
    .led_strap_pin_two_oe(o2), .led_strap_pin_three_level(p3),
    .led_strap_pin_three_drive(d3), .led_strap_pin_three_oe(o3), .tck(tck), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .hardware_reset_state(hrst),
    .soft_power_down_mode(spd_mode));
  pmdp_mac_model i_mac (
    .mii_txc(tx_clk_w), .mii_rxc(rx_clk_w), .rxd_w(rxd_w), .rx_dv_w(rx_dv_w),
    .rx_er_w(rx_er_w), .go(go), .txd(txd), .tx_en(tx_en), .rx_acc(rx_acc),
    .rx_cnt(rx_cnt), .er_seen(er_seen));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(negedge tx_clk_w) begin
    if (ltx_en === 1'b1) begin
      tx_acc <= {tx_acc[11:0], ltx};
      tx_n <= tx_n + 1;
    end
  end
  // Whole run is well under this; a hang lands in the report
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Zero-wait slave, yet every phase still waits for hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= pmdp_pkg::HSIZE_WORD;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    check(hresp, pmdp_pkg::HRESP_OKAY);
  endtask
  task automatic half_chk(input int exp);
    int n;
    n = 0;
    @(posedge tx_clk_w);
    @(negedge clk_sys);
    while (tx_clk_w === 1'b1 && n < 50) begin
      check(rx_clk_w, tx_clk_w);
      n++;
      @(negedge clk_sys);
    end
    check(n, exp);
  endtask
  task automatic wait_run(input int lo);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (hrst !== 1'b0 && n < 100) begin
      n++;
      @(negedge clk_sys);
    end
    check(n >= lo && n <= lo + 2, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs}, 10'h300);
    check({hrst, o1, o2, o3}, 4'h8);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    wait_run(EXT);
    bus(1'b0, pmdp_pkg::ADDR_CTRL, 32'h0);
    check(rd & (SPD | FDX | PWD | ISO | SRST), 32'h00000000);
    bus(1'b0, pmdp_pkg::ADDR_LED_CFG, 32'h0);
    check(rd[5:0], pmdp_pkg::LED_CFG_ALT);
    bus(1'b0, pmdp_pkg::ADDR_STATUS, 32'h0);
    check(rd[2:0], {s3, s2, s1});
    bus(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h00000000);
  endtask
  task automatic t_tx(input logic fdx);
    int base;
    base = tx_n;
    bus(1'b1, pmdp_pkg::ADDR_CTRL, fdx ? FDX : 32'h0);
    @(posedge clk_sys);
    go <= 1'b1;
    repeat (25) @(negedge clk_sys);
    check(crs, !fdx);
    repeat (60) @(posedge clk_sys);
    check(tx_acc, 16'h1248);
    check(tx_n - base, 4);
    go <= 1'b0;
    // The model must see go low on a clock edge before the next frame
    repeat (2) @(posedge tx_clk_w);
  endtask
  task automatic t_rx();
    for (int i = 0; i < 5; i++) begin
      @(posedge rx_clk_w);
      @(posedge clk_sys);
      lnb <= (i < 4) ? (4'h1 << i) : 4'hF;
      lv <= (i < 4);
      le <= (i == 3);
    end
    repeat (2) @(posedge rx_clk_w);
    repeat (2) @(negedge clk_sys);
    check(rx_acc, 16'h1248);
    check(rx_cnt, 4'h4);
    check({er_seen, rx_er}, 2'h2);
    check(rxd, 4'h0);
  endtask
  task automatic t_crs_col();
    bus(1'b1, pmdp_pkg::ADDR_CTRL, 32'h0);
    bus(1'b1, pmdp_pkg::ADDR_LED_CFG,
        {26'h0000000, pmdp_pkg::LED_CARRIER, pmdp_pkg::LED_COLL, pmdp_pkg::LED_CARRIER});
    lc <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check(crs, 1'b1);
    drv = d1;
    check(d2, 1'b0);
    @(posedge rx_clk_w);
    @(posedge clk_sys);
    lc <= 1'b0;
    repeat (4) @(negedge clk_sys);
    check(crs, 1'b1);
    repeat (12) @(negedge clk_sys);
    check(crs, 1'b0);
    check(d1 !== drv, 1'b1);
    @(posedge clk_sys);
    lcol <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check(col, 1'b1);
    repeat (30) @(negedge clk_sys);
    check(col, 1'b1);
    check(d2, 1'b1);
    bus(1'b1, pmdp_pkg::ADDR_CTRL, FDX);
    repeat (3) @(negedge clk_sys);
    check(col, 1'b0);
    @(posedge clk_sys);
    lcol <= 1'b0;
  endtask
  task automatic t_modes();
    bus(1'b1, pmdp_pkg::ADDR_CTRL, PWD);
    lc <= 1'b1;
    lv <= 1'b1;
    repeat (12) @(negedge clk_sys);
    check({spd_mode, crs, rx_dv, rxd, col}, 8'h80);
    half_chk(H10);
    bus(1'b1, pmdp_pkg::ADDR_CTRL, ISO);
    repeat (3) @(negedge clk_sys);
    check({oen, rx_clk_w, rxd_w}, 6'h00);
    @(posedge clk_sys);
    lc <= 1'b0;
    lv <= 1'b0;
    bus(1'b1, pmdp_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(negedge clk_sys);
    check(oen, 1'b1);
  endtask
  task automatic t_soft();
    bus(1'b1, pmdp_pkg::ADDR_CTRL, SRST);
    bus(1'b0, pmdp_pkg::ADDR_STATUS, 32'h0);
    check({rd[pmdp_pkg::STAT_BUSY_BIT], hrst}, 2'h3);
    // Three edges of the extension already passed during the status read
    wait_run(EXT - 3);
    bus(1'b0, pmdp_pkg::ADDR_LED_CFG, 32'h0);
    check(rd[5:0], pmdp_pkg::LED_CFG_ALT);
  endtask
  // Scan clock runs only inside the shift, off the system clock's phase
  task automatic t_jtag();
    logic [7:0] pat;
    pat = 8'hB2;
    trst_n <= 1'b1;
    #7;
    for (int i = 0; i < 8; i++) begin
      #160 tck = 1'b0;
      tdi = pat[i];
      #160 tck = 1'b1;
      if (i > 0) check(tdo, pat[i - 1]);
    end
    @(posedge clk_sys);
    trst_n <= 1'b0;
    repeat (5) @(negedge clk_sys);
    check(tdo, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, hwrite, go, lv, le, lc, lcol, tck, tdi, trst_n} = 10'h000;
    {s3, s2, s1} = 3'b100;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    lnb = 4'h0;
    tx_acc = 16'h0000;
    {n_mismatch, cmp_count, tx_n, cyc} = 0;
    repeat (10) @(posedge clk_sys);
    t_reset();
    half_chk(H10);
    bus(1'b1, pmdp_pkg::ADDR_CTRL, SPD);
    half_chk(H100);
    t_tx(1'b0);
    t_tx(1'b1);
    t_rx();
    t_crs_col();
    t_modes();
    t_soft();
    t_jtag();
    close_out();
  end
endmodule
`default_nettype wire
